// ### core/apc_params.svh
// Register offsets, field positions, reset values for analog path control
`ifndef APC_PARAMS_SVH
`define APC_PARAMS_SVH
`define APC_ADDR_W          8
`define APC_DATA_W          16
`define APC_OFF_RIGHT_IN    8'h2F
`define APC_OFF_RIGHT_GAIN  8'h2D
`define APC_OFF_HP_LEFT     8'h39
`define APC_OFF_HP_RIGHT    8'h3A
`define APC_OFF_LINE_LEFT   8'h3B
`define APC_OFF_LINE_RIGHT  8'h3C
`define APC_OFF_ZC_IN       8'h70
`define APC_BIT_CM          6
`define APC_MSB_INV         5
`define APC_LSB_INV         4
`define APC_MSB_NONINV      3
`define APC_LSB_NONINV      2
`define APC_MSB_MODE        1
`define APC_BIT_MUTE        8
`define APC_BIT_VU          7
`define APC_BIT_ZC          6
`define APC_MSB_LVL         5
`define APC_GAIN_MSB        4
`define APC_RST_CM          1'h1
`define APC_RST_INV         2'h0
`define APC_RST_NONINV      2'h1
`define APC_RST_HP_LVL      6'h2D
`define APC_RST_LINE_LVL    6'h39
`define APC_RST_GAIN        5'h05
`define APC_NCH             4
`endif

// ### core/apc_pkg.sv
// Types for the analog path control register bank
package apc_pkg;
  typedef enum logic [1:0] {
    APC_SINGLE   = 2'h0,
    APC_DIFFLINE = 2'h1,
    APC_DIFFMIC  = 2'h2,
    APC_RSVD     = 2'h3
  } apc_mode_t;
  typedef enum logic [1:0] {
    APC_PIN_NONE   = 2'h0,
    APC_PIN_FIRST  = 2'h1,
    APC_PIN_SECOND = 2'h2,
    APC_PIN_THIRD  = 2'h3
  } apc_pin_t;
  typedef struct packed {
    logic       mute;
    logic       zeroCrossEn;
    logic [5:0] level;
  } apc_out_t;
  typedef struct packed {
    apc_mode_t  mode;
    apc_pin_t   invPin;
    apc_pin_t   nonInvPin;
    logic       cmRejectOn;
    logic       micTable;
    logic [4:0] gain;
  } apc_right_in_t;
endpackage

// ### core/apc_level_stage.sv
// One output channel: pending level, update and zero-cross apply
`timescale 1ns/100ps
`include "apc_params.svh"
module apc_level_stage
  import apc_pkg::*;
#(
  parameter logic [5:0] RST_LEVEL = 6'h39
) (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       wrLevel,
  input  wire logic [8:0] wrData,
  input  wire logic       update,
  input  wire logic       zeroCross,
  output apc_out_t        active,
  output logic [8:0]      readBack
);
  logic       mute_r;
  logic       zc_r;
  logic [5:0] pend_r;
  logic [5:0] act_r;
  logic       armed_r;
  logic       applyNow;
  logic       armNext;
  logic [5:0] applyLevel;

  // Zero-cross holds the change until the channel crosses
  assign applyNow   = (update & ~zc_r) | (armed_r & zc_r & zeroCross);
  // A crossing applies the level and an update in that same cycle re-arms, so none is lost
  assign armNext    = zc_r & (update | (armed_r & ~zeroCross));
  // Level written beside the update bit leaves with that update
  assign applyLevel = wrLevel ? wrData[`APC_MSB_LVL:0] : pend_r;

  always_ff @(posedge clk) begin
    if (rst) begin
      mute_r  <= 1'h0;
      zc_r    <= 1'h0;
      pend_r  <= RST_LEVEL;
      act_r   <= RST_LEVEL;
      armed_r <= 1'h0;
    end else begin
      if (wrLevel) begin
        mute_r <= wrData[`APC_BIT_MUTE];
        zc_r   <= wrData[`APC_BIT_ZC];
        pend_r <= wrData[`APC_MSB_LVL:0];
      end
      if (applyNow)
        act_r <= applyLevel;
      armed_r <= armNext;
    end
  end

  assign active = {mute_r, zc_r, act_r};
  // Update bit never stored, reads zero
  assign readBack = {mute_r, 1'h0, zc_r, pend_r};
endmodule

// ### core/analog_path_control_regs.sv
// Analog path control register bank: right input and output levels
// Function
// - Right mode: single, diff line, diff mic
// - Common-mode reject resets on, diff line only
// - Inverting select bits 5:4, reset 00
// - Non-inverting select bits 3:2, reset 01
// - Headphone mute bit 8 per channel
// - Headphone update applies both levels together
// - Line update applies both line levels together
// - Headphone zero-cross enable bit 6
// - Level code 0 is -57dB, 1dB steps
// - Headphone levels reset to 2D
// - Line left level resets to 39
// - Line left mute bit 8
// - Line left zero-cross enable bit 6
// - Gain table depends on right mode
//
// Added by the designer: the address-and-strobe port.
`timescale 1ns/100ps
`include "apc_params.svh"
module analog_path_control_regs
  import apc_pkg::*;
#(
  parameter int ADDR_W = `APC_ADDR_W,
  parameter int DATA_W = `APC_DATA_W
) (
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic [ADDR_W-1:0] regAddr,
  input  wire logic [DATA_W-1:0] regWrData,
  input  wire logic              regWrite,
  input  wire logic              regRead,
  output logic      [DATA_W-1:0] regRdData,
  input  wire logic [3:0]        zeroCrossIn,
  output apc_right_in_t          rightIn,
  output apc_out_t               hpLeftOut,
  output apc_out_t               hpRightOut,
  output apc_out_t               lineLeftOut,
  output apc_out_t               lineRightOut
);
  // ==========================================================
  // Zero-cross pins synchronised, two flops
  // ==========================================================
  logic [3:0] zcMeta_r;
  logic [3:0] zcSync_r;
  always_ff @(posedge clk) begin
    if (rst) begin
      zcMeta_r <= 4'h0;
      zcSync_r <= 4'h0;
    end else begin
      zcMeta_r <= zeroCrossIn;
      zcSync_r <= zcMeta_r;
    end
  end

  // ==========================================================
  // Address decode
  // ==========================================================
  logic selIn;
  logic selGain;
  logic selHpL;
  logic selHpR;
  logic selLnL;
  logic selLnR;
  logic hpUpdate;
  logic lineUpdate;
  assign selIn   = regAddr == `APC_OFF_RIGHT_IN;
  assign selGain = regAddr == `APC_OFF_RIGHT_GAIN;
  assign selHpL  = regAddr == `APC_OFF_HP_LEFT;
  assign selHpR  = regAddr == `APC_OFF_HP_RIGHT;
  assign selLnL  = regAddr == `APC_OFF_LINE_LEFT;
  assign selLnR  = regAddr == `APC_OFF_LINE_RIGHT;
  // Update bit lives in both registers of a pair
  assign hpUpdate   = regWrite & (selHpL | selHpR) &
                      regWrData[`APC_BIT_VU];
  assign lineUpdate = regWrite & (selLnL | selLnR) &
                      regWrData[`APC_BIT_VU];

  // ==========================================================
  // Right input configuration
  // ==========================================================
  logic [1:0] mode_r;
  logic [1:0] inv_r;
  logic [1:0] nonInv_r;
  logic       cm_r;
  logic [4:0] gain_r;
  always_ff @(posedge clk) begin
    if (rst) begin
      mode_r   <= APC_SINGLE;
      cm_r     <= `APC_RST_CM;
      inv_r    <= `APC_RST_INV;
      nonInv_r <= `APC_RST_NONINV;
      gain_r   <= `APC_RST_GAIN;
    end else begin
      if (regWrite & selIn) begin
        mode_r   <= regWrData[`APC_MSB_MODE:0];
        cm_r     <= regWrData[`APC_BIT_CM];
        inv_r    <= regWrData[`APC_MSB_INV:`APC_LSB_INV];
        nonInv_r <= regWrData[`APC_MSB_NONINV:`APC_LSB_NONINV];
      end
      if (regWrite & selGain)
        gain_r <= regWrData[`APC_GAIN_MSB:0];
    end
  end

  function automatic apc_pin_t pinOf(input logic [1:0] code);
    pinOf = code[1] ? APC_PIN_THIRD :
            (code[0] ? APC_PIN_SECOND : APC_PIN_FIRST);
  endfunction

  logic     isMic;
  logic     isRsvd;
  apc_pin_t invSide;
  apc_pin_t nonInvSide;
  // Mic mode swaps which field drives which side
  assign isMic      = mode_r == APC_DIFFMIC;
  assign isRsvd     = mode_r == APC_RSVD;
  assign invSide    = isRsvd ? APC_PIN_NONE :
                      pinOf(isMic ? nonInv_r : inv_r);
  assign nonInvSide = isRsvd ? APC_PIN_NONE :
                      pinOf(isMic ? inv_r : nonInv_r);

  apc_right_in_t rightIn_r;
  always_ff @(posedge clk) begin
    if (rst) begin
      // Reset image equals the decoded register defaults
      rightIn_r.mode       <= APC_SINGLE;
      rightIn_r.invPin     <= APC_PIN_FIRST;
      rightIn_r.nonInvPin  <= APC_PIN_SECOND;
      rightIn_r.cmRejectOn <= 1'h0;
      rightIn_r.micTable   <= 1'h0;
      rightIn_r.gain       <= `APC_RST_GAIN;
    end else begin
      rightIn_r.mode       <= apc_mode_t'(mode_r);
      rightIn_r.invPin     <= invSide;
      rightIn_r.nonInvPin  <= nonInvSide;
      rightIn_r.cmRejectOn <= cm_r & (mode_r == APC_DIFFLINE);
      rightIn_r.micTable   <= isMic;
      rightIn_r.gain       <= gain_r;
    end
  end
  assign rightIn = rightIn_r;

  // ==========================================================
  // Output level channels: hp left, hp right, line left, right
  // ==========================================================
  apc_out_t   chAct [`APC_NCH];
  logic [8:0] chRd  [`APC_NCH];
  logic [3:0] chWr;
  logic [3:0] chUpd;
  assign chWr  = {selLnR, selLnL, selHpR, selHpL} & {4{regWrite}};
  assign chUpd = {lineUpdate, lineUpdate, hpUpdate, hpUpdate};

  apc_level_stage #(.RST_LEVEL(`APC_RST_HP_LVL)) uHpL (
    .clk       (clk),
    .rst       (rst),
    .wrLevel   (chWr[0]),
    .wrData    (regWrData[8:0]),
    .update    (chUpd[0]),
    .zeroCross (zcSync_r[0]),
    .active    (chAct[0]),
    .readBack  (chRd[0])
  );
  apc_level_stage #(.RST_LEVEL(`APC_RST_HP_LVL)) uHpR (
    .clk       (clk),
    .rst       (rst),
    .wrLevel   (chWr[1]),
    .wrData    (regWrData[8:0]),
    .update    (chUpd[1]),
    .zeroCross (zcSync_r[1]),
    .active    (chAct[1]),
    .readBack  (chRd[1])
  );
  apc_level_stage #(.RST_LEVEL(`APC_RST_LINE_LVL)) uLnL (
    .clk       (clk),
    .rst       (rst),
    .wrLevel   (chWr[2]),
    .wrData    (regWrData[8:0]),
    .update    (chUpd[2]),
    .zeroCross (zcSync_r[2]),
    .active    (chAct[2]),
    .readBack  (chRd[2])
  );
  apc_level_stage #(.RST_LEVEL(`APC_RST_LINE_LVL)) uLnR (
    .clk       (clk),
    .rst       (rst),
    .wrLevel   (chWr[3]),
    .wrData    (regWrData[8:0]),
    .update    (chUpd[3]),
    .zeroCross (zcSync_r[3]),
    .active    (chAct[3]),
    .readBack  (chRd[3])
  );

  apc_out_t hpL_r;
  apc_out_t hpR_r;
  apc_out_t lnL_r;
  apc_out_t lnR_r;
  always_ff @(posedge clk) begin
    if (rst) begin
      hpL_r <= {2'h0, `APC_RST_HP_LVL};
      hpR_r <= {2'h0, `APC_RST_HP_LVL};
      lnL_r <= {2'h0, `APC_RST_LINE_LVL};
      lnR_r <= {2'h0, `APC_RST_LINE_LVL};
    end else begin
      hpL_r <= chAct[0];
      hpR_r <= chAct[1];
      lnL_r <= chAct[2];
      lnR_r <= chAct[3];
    end
  end
  assign hpLeftOut    = hpL_r;
  assign hpRightOut   = hpR_r;
  assign lineLeftOut  = lnL_r;
  assign lineRightOut = lnR_r;

  // ==========================================================
  // Read path, data one cycle after strobe
  // ==========================================================
  logic              selZc;
  logic [DATA_W-1:0] rdIn;
  logic [DATA_W-1:0] rdGain;
  logic [DATA_W-1:0] rdHpL;
  logic [DATA_W-1:0] rdHpR;
  logic [DATA_W-1:0] rdLnL;
  logic [DATA_W-1:0] rdLnR;
  logic [DATA_W-1:0] rdZc;
  logic [DATA_W-1:0] rdMux;
  logic [DATA_W-1:0] rdData_r;
  assign selZc  = regAddr == `APC_OFF_ZC_IN;
  // Selects are one-hot, so the read mux is a plain OR
  assign rdIn   = selIn   ? DATA_W'({cm_r, inv_r, nonInv_r, mode_r}) : '0;
  assign rdGain = selGain ? DATA_W'(gain_r) : '0;
  assign rdHpL  = selHpL  ? DATA_W'(chRd[0]) : '0;
  assign rdHpR  = selHpR  ? DATA_W'(chRd[1]) : '0;
  assign rdLnL  = selLnL  ? DATA_W'(chRd[2]) : '0;
  assign rdLnR  = selLnR  ? DATA_W'(chRd[3]) : '0;
  assign rdZc   = selZc   ? DATA_W'(zcSync_r) : '0;
  assign rdMux  = rdIn | rdGain | rdHpL | rdHpR | rdLnL | rdLnR | rdZc;

  // Holds data only in the cycle after a read
  always_ff @(posedge clk) begin
    if (rst)
      rdData_r <= '0;
    else
      rdData_r <= regRead ? rdMux : '0;
  end
  assign regRdData = rdData_r;
endmodule

// ### verification/apc_checker.sv
// Port checks for the analog path control register bank
`timescale 1ns/100ps
module apc_checker
  import apc_pkg::*;
(
  input wire logic          clk,
  input wire logic          rst,
  input wire logic [7:0]    regAddr,
  input wire logic [15:0]   regWrData,
  input wire logic          regWrite,
  input wire logic          regRead,
  input wire logic [15:0]   regRdData,
  input wire logic [3:0]    zeroCrossIn,
  input wire apc_right_in_t rightIn,
  input wire apc_out_t      hpLeftOut,
  input wire apc_out_t      hpRightOut,
  input wire apc_out_t      lineLeftOut,
  input wire apc_out_t      lineRightOut
);
  // ==========
  // Helpers
  logic [1:0] hpUpd_r;
  wire  [1:0] hpUpd_nxt;
  wire        hpUpdWr;
  assign hpUpdWr = regWrite && regWrData[7]
                   && (regAddr == 8'h39 || regAddr == 8'h3A);
  assign hpUpd_nxt = {hpUpd_r[0], hpUpdWr};
  always_ff @(posedge clk) begin
    if (rst) hpUpd_r <= 2'h0;
    else hpUpd_r <= hpUpd_nxt;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_wr(logic [7:0] a);
    regWrite && regAddr == a;
  endsequence
  // ==========
  // Assertions
  a_hpl_mute: assert property (s_wr(8'h39) |-> ##2
    hpLeftOut.mute == $past(regWrData[8], 2)) else $error("hp left mute");
  a_hpr_mute: assert property (s_wr(8'h3A) |-> ##2
    hpRightOut.mute == $past(regWrData[8], 2)) else $error("hp right mute");
  a_hpl_zc: assert property (s_wr(8'h39) |-> ##2
    hpLeftOut.zeroCrossEn == $past(regWrData[6], 2)) else $error("hp zc");
  a_line_mute: assert property (s_wr(8'h3B) |-> ##2
    lineLeftOut.mute == $past(regWrData[8], 2)) else $error("line mute");
  a_line_zc: assert property (s_wr(8'h3B) |-> ##2
    lineLeftOut.zeroCrossEn == $past(regWrData[6], 2)) else $error("line zc");
  a_vu_reads_zero: assert property (regRead
    && regAddr inside {8'h39, 8'h3A, 8'h3B} |=> !regRdData[7])
    else $error("update bit read back");
  a_cm_line_only: assert property (rightIn.cmRejectOn |->
    rightIn.mode == APC_DIFFLINE) else $error("cm reject outside line");
  a_mic_table: assert property (rightIn.micTable ==
    (rightIn.mode == APC_DIFFMIC)) else $error("gain table select");
  a_hp_lvl_cause: assert property ($changed(hpLeftOut.level)
    && !$past(hpLeftOut.zeroCrossEn) |-> hpUpd_r[1])
    else $error("level moved");
endmodule
bind analog_path_control_regs apc_checker i_apc_checker(.clk(clk),
  .rst(rst), .regAddr(regAddr), .regWrData(regWrData),
  .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
  .zeroCrossIn(zeroCrossIn), .rightIn(rightIn), .hpLeftOut(hpLeftOut),
  .hpRightOut(hpRightOut), .lineLeftOut(lineLeftOut),
  .lineRightOut(lineRightOut));

// ### verification/tb_top.sv
// Self-checking bench for the analog path control register bank
`timescale 1ns/100ps
module tb_top;
  import apc_pkg::*;
  logic          clk = 1'b0;
  logic          rst = 1'b1;
  logic          regWrite = 1'b0;
  logic          regRead = 1'b0;
  logic          rdD = 1'b0;
  logic [7:0]    regAddr = 8'h00;
  logic [15:0]   regWrData = 16'h0000;
  logic [3:0]    zeroCrossIn = 4'h0;
  logic [15:0]   regRdData;
  logic [15:0]   expQ[$];
  logic [31:0]   seed = 32'd80969;
  apc_right_in_t rightIn;
  apc_out_t      hpLeftOut, hpRightOut, lineLeftOut, lineRightOut;
  int            error_cnt = 0;
  int            comparisons = 0;
  always #4 clk = ~clk;
  analog_path_control_regs i_analog_path_control_regs(.clk(clk),
    .rst(rst), .regAddr(regAddr), .regWrData(regWrData),
    .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
    .zeroCrossIn(zeroCrossIn), .rightIn(rightIn), .hpLeftOut(hpLeftOut),
    .hpRightOut(hpRightOut), .lineLeftOut(lineLeftOut),
    .lineRightOut(lineRightOut));
  // ==========
  // Tasks
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic apc_pin_t pin(input logic [1:0] f);
    return f[1] ? APC_PIN_THIRD : (f[0] ? APC_PIN_SECOND : APC_PIN_FIRST);
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // wr, rd and idle each set both strobes, so back-to-back calls never clash
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    regAddr <= a;
    regWrData <= d;
    regWrite <= 1'b1;
    regRead <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    regAddr <= a;
    regRead <= 1'b1;
    regWrite <= 1'b0;
    expQ.push_back(e);
    @(posedge clk);
  endtask
  task automatic idle(input int n);
    regRead <= 1'b0;
    regWrite <= 1'b0;
    repeat (n) @(posedge clk);
  endtask
  task automatic give_verdict();
    if (error_cnt == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // Read data stands only in the cycle after the strobe
  always @(posedge clk) begin
    rdD <= regRead && !rst;
    if (rdD) chk(regRdData, expQ.pop_front());
  end
  initial begin
    repeat (5000) @(posedge clk);
    error_cnt++;
    give_verdict();
  end
  // ==========
  // Scenarios
  initial begin
    logic [15:0]   d;
    logic [5:0]    a, b, c, dd, e, f;
    logic [4:0]    g;
    logic [1:0]    md;
    apc_right_in_t x;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(8'h2F, 16'h0044);
    rd(8'h39, 16'h002D);
    rd(8'h3A, 16'h002D);
    rd(8'h3B, 16'h0039);
    rd(8'h50, 16'h0000);
    chk({8'h00, hpLeftOut}, 16'h002D);
    chk({8'h00, lineLeftOut}, 16'h0039);
    for (int i = 0; i < 4; i++) begin
      md = 2'(i);
      d = {9'h000, 1'b1, 4'(xs()), md};
      wr(8'h2F, d);
      rd(8'h2F, d);
      idle(3);
      x.mode = apc_mode_t'(md);
      x.invPin = pin(md == 2'h2 ? d[3:2] : d[5:4]);
      x.nonInvPin = pin(md == 2'h2 ? d[5:4] : d[3:2]);
      if (md == 2'h3) x.invPin = APC_PIN_NONE;
      if (md == 2'h3) x.nonInvPin = APC_PIN_NONE;
      x.cmRejectOn = md == 2'h1;
      x.micTable = md == 2'h2;
      x.gain = 5'h05;
      chk({3'h0, rightIn}, {3'h0, x});
    end
    g = 5'(xs());
    wr(8'h2D, {11'h000, g});
    rd(8'h2D, {11'h000, g});
    idle(2);
    chk({11'h000, rightIn.gain}, {11'h000, g});
    a = 6'(xs());
    b = 6'(xs());
    c = 6'(xs());
    dd = 6'(xs());
    e = a ^ 6'h15;
    wr(8'h39, {10'h000, a});
    wr(8'h3A, {10'h000, b});
    idle(3);
    chk({8'h00, hpLeftOut}, 16'h002D);
    wr(8'h39, {10'h006, a});
    rd(8'h39, {10'h004, a});
    idle(3);
    chk({8'h00, hpLeftOut}, {9'h001, 1'b0, a});
    chk({8'h00, hpRightOut}, {10'h000, b});
    // Line left zero-cross on: its level must wait for a crossing
    wr(8'h3B, {10'h005, c});
    wr(8'h3C, {10'h000, dd});
    wr(8'h3C, {10'h002, dd});
    idle(3);
    chk({8'h00, lineLeftOut}, 16'h00F9);
    chk({8'h00, lineRightOut}, {10'h000, dd});
    wr(8'h39, {10'h001, e});
    wr(8'h39, {10'h003, e});
    idle(6);
    chk({8'h00, hpLeftOut}, {9'h000, 1'b1, a});
    zeroCrossIn <= 4'h5;
    idle(4);
    rd(8'h70, 16'h0005);
    zeroCrossIn <= 4'h0;
    idle(6);
    chk({8'h00, hpLeftOut}, {9'h000, 1'b1, e});
    chk({8'h00, lineLeftOut}, {9'h003, c});
    // Level written with the update bit goes out at once
    f = b ^ 6'h2A;
    wr(8'h3A, {10'h002, f});
    idle(3);
    chk({8'h00, hpRightOut}, {10'h000, f});
    // Second reset in mid-run brings back every default
    rst <= 1'h1;
    idle(2);
    rst <= 1'h0;
    idle(2);
    chk({8'h00, hpRightOut}, 16'h002D);
    chk({8'h00, lineLeftOut}, 16'h0039);
    chk({3'h0, rightIn}, {3'h0, APC_SINGLE, APC_PIN_FIRST,
                          APC_PIN_SECOND, 2'h0, 5'h05});
    rd(8'h3A, 16'h002D);
    idle(2);
    give_verdict();
  end
endmodule
